// [hdl/relay_alarm_pkg.sv]
// shared register map, field layout and sizes for the relay alarm output block
package relay_alarm_pkg;
   localparam int CNT_W = 16;
   localparam int VOLT_W = 16;
   // word byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_UV_THR = 8'h04;
   localparam logic [7:0] ADDR_RC1_THR = 8'h08;
   localparam logic [7:0] ADDR_RC2_THR = 8'h0c;
   localparam logic [7:0] ADDR_OC_THR = 8'h10;
   localparam logic [7:0] ADDR_RC1_CNT = 8'h14;
   localparam logic [7:0] ADDR_RC2_CNT = 8'h18;
   localparam logic [7:0] ADDR_OC_CNT = 8'h1c;
   localparam logic [7:0] ADDR_ALARMS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
   localparam logic [7:0] ADDR_SEAL_CLR = 8'h2c;
   // ctrl fields
   localparam int CTRL_DELTA_BIT = 0;
   localparam int CTRL_LOCKOUT_FIRST_BIT = 1;
   localparam int CTRL_TGT_RESET_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   // alarm vector layout (alarms, status, mask, seal clear)
   localparam int NUM_ALARMS = 14;
   localparam int AL_PHASE_HS = 0;
   localparam int AL_GROUND_HS = 1;
   localparam int AL_TGT_A = 2;
   localparam int AL_TGT_B = 3;
   localparam int AL_TGT_C = 4;
   localparam int AL_UV = 5;
   localparam int AL_RECL_DIS = 6;
   localparam int AL_RC1 = 7;
   localparam int AL_RC2 = 8;
   localparam int AL_OC = 9;
   localparam int AL_PHASE_HS_SEAL = 10;
   localparam int AL_GROUND_HS_SEAL = 11;
   localparam int AL_UV_SEAL = 12;
   localparam int AL_RC_SEAL = 13;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] THR_RESET = 16'hffff;
   localparam logic [VOLT_W-1:0] UV_THR_RESET = 16'h0000;
   localparam logic [NUM_ALARMS-1:0] MASK_RESET = 14'h0000;
endpackage

// [hdl/wb_reg_slave.sv]
// classic wishbone single-cycle slave front end: one-cycle ack, error-free decode
`timescale 1ns/100ps
`default_nettype none
module wb_reg_slave (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   output logic o_wb_ack,
   output logic o_wr_pulse,
   output logic o_rd_pulse
);
   logic ack_q;
   logic req;

   // ack drops the cycle after it is given, so a request held through its ack is taken once
   assign req = i_wb_cyc & i_wb_stb & ~ack_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wr_pulse = req & i_wb_we;
   assign o_rd_pulse = req & ~i_wb_we;
endmodule
`default_nettype wire

// [hdl/relay_alarm_output_logic.sv]
// relay logical alarm outputs with wishbone settings, counters and interrupt
`timescale 1ns/100ps
`default_nettype none
module relay_alarm_output_logic #(
   parameter int CNT_W = relay_alarm_pkg::CNT_W,
   parameter int VOLT_W = relay_alarm_pkg::VOLT_W
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_phase_hs_energized,
   input wire logic i_ground_hs_energized,
   input wire logic i_target_a_set,
   input wire logic i_target_b_set,
   input wire logic i_target_c_set,
   input wire logic i_target_reset_button,
   input wire logic [VOLT_W-1:0] i_volt_a,
   input wire logic [VOLT_W-1:0] i_volt_b,
   input wire logic [VOLT_W-1:0] i_volt_c,
   input wire logic [VOLT_W-1:0] i_volt_ab,
   input wire logic [VOLT_W-1:0] i_volt_bc,
   input wire logic [VOLT_W-1:0] i_volt_ca,
   input wire logic i_recloser_block_input,
   input wire logic i_reclose_op,
   input wire logic i_oc_trip_op,
   output logic o_phase_highset_trip_alarm,
   output logic o_phase_highset_trip_sealed,
   output logic o_ground_highset_trip_alarm,
   output logic o_ground_highset_trip_sealed,
   output logic o_phase_a_target_alarm,
   output logic o_phase_b_target_alarm,
   output logic o_phase_c_target_alarm,
   output logic o_single_phase_undervolt_alarm,
   output logic o_single_phase_undervolt_sealed,
   output logic o_recloser_disabled_alarm,
   output logic o_recloser_out_target,
   output logic o_reclose_count_alarm_first,
   output logic o_reclose_count_sealed_first,
   output logic o_reclose_count_alarm_second,
   output logic o_reclose_count_sealed_second,
   output logic o_overcurrent_trip_count_alarm,
   output logic o_irq
);
   localparam int NA = relay_alarm_pkg::NUM_ALARMS;

   // saturate so a busy feeder never wraps back under its threshold
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction

   // strict compare: the alarm needs one count past the setting
   function automatic logic over_thr(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] thr);
      over_thr = cnt > thr;
   endfunction

   // byte lanes left out of sel keep their old contents
   function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      byte_merge = r;
   endfunction

   logic wr;
   logic rd;
   logic [31:0] wdat_ctrl;
   logic [2:0] ctrl_q;
   logic [VOLT_W-1:0] uv_thr_q;
   logic [CNT_W-1:0] rc1_thr_q;
   logic [CNT_W-1:0] rc2_thr_q;
   logic [CNT_W-1:0] oc_thr_q;
   logic [CNT_W-1:0] rc1_cnt_q;
   logic [CNT_W-1:0] rc2_cnt_q;
   logic [CNT_W-1:0] oc_cnt_q;
   logic tgt_a_q;
   logic tgt_b_q;
   logic tgt_c_q;
   logic phase_seal_q;
   logic ground_seal_q;
   logic uv_seal_q;
   logic rc1_seal_q;
   logic rc2_seal_q;
   logic [NA-1:0] irq_stat_q;
   logic [NA-1:0] irq_mask_q;
   logic [NA-1:0] alarms;
   logic [NA-1:0] alarms_prev_q;
   logic [NA-1:0] seal_clr;
   logic target_reset;
   logic uv_now;
   logic [31:0] rdata_q;
   logic [NA-1:0] alarm_rise;
   logic ctrl_wr;

   // a request held through its ack is taken only once
   wb_reg_slave u_wb (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we),
      .o_wb_ack(o_wb_ack),
      .o_wr_pulse(wr),
      .o_rd_pulse(rd)
   );

   function automatic logic wr_at(input logic w, input logic [7:0] a, input logic [7:0] off);
      wr_at = w && (a == off);
   endfunction

   assign ctrl_wr = wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_CTRL);
   assign wdat_ctrl = byte_merge({29'h0, ctrl_q}, i_wb_dat, i_wb_sel);

   // remote target reset is a self-clearing control bit
   assign target_reset = i_target_reset_button |
      (ctrl_wr & wdat_ctrl[relay_alarm_pkg::CTRL_TGT_RESET_BIT]);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q <= relay_alarm_pkg::CTRL_RESET;
      end else if (ctrl_wr) begin
         // bit 2 is never stored, so it reads back as zero
         ctrl_q <= {1'b0, wdat_ctrl[1:0]};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         uv_thr_q <= relay_alarm_pkg::UV_THR_RESET;
         // all-ones keeps the count alarms quiet until software sets one
         rc1_thr_q <= relay_alarm_pkg::THR_RESET;
         rc2_thr_q <= relay_alarm_pkg::THR_RESET;
         oc_thr_q <= relay_alarm_pkg::THR_RESET;
      end else begin
         if (wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_UV_THR)) begin
            uv_thr_q <= VOLT_W'(byte_merge(32'(uv_thr_q), i_wb_dat, i_wb_sel));
         end
         // each threshold stands alone
         if (wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_RC1_THR)) begin
            rc1_thr_q <= CNT_W'(byte_merge(32'(rc1_thr_q), i_wb_dat, i_wb_sel));
         end
         if (wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_RC2_THR)) begin
            rc2_thr_q <= CNT_W'(byte_merge(32'(rc2_thr_q), i_wb_dat, i_wb_sel));
         end
         if (wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_OC_THR)) begin
            oc_thr_q <= CNT_W'(byte_merge(32'(oc_thr_q), i_wb_dat, i_wb_sel));
         end
      end
   end

   // software write presets a counter; an op in the same cycle is then dropped
   // both reclose counters see every op; only their thresholds differ
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rc1_cnt_q <= relay_alarm_pkg::CNT_RESET;
         rc2_cnt_q <= relay_alarm_pkg::CNT_RESET;
         oc_cnt_q <= relay_alarm_pkg::CNT_RESET;
      end else begin
         if (wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_RC1_CNT)) begin
            rc1_cnt_q <= CNT_W'(byte_merge(32'(rc1_cnt_q), i_wb_dat, i_wb_sel));
         end else if (i_reclose_op) begin
            rc1_cnt_q <= sat_inc(rc1_cnt_q);
         end
         if (wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_RC2_CNT)) begin
            rc2_cnt_q <= CNT_W'(byte_merge(32'(rc2_cnt_q), i_wb_dat, i_wb_sel));
         end else if (i_reclose_op) begin
            rc2_cnt_q <= sat_inc(rc2_cnt_q);
         end
         if (wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_OC_CNT)) begin
            oc_cnt_q <= CNT_W'(byte_merge(32'(oc_cnt_q), i_wb_dat, i_wb_sel));
         end else if (i_oc_trip_op) begin
            oc_cnt_q <= sat_inc(oc_cnt_q);
         end
      end
   end

   // targets: a new fault sets over a reset in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tgt_a_q <= 1'b0;
         tgt_b_q <= 1'b0;
         tgt_c_q <= 1'b0;
      end else begin
         tgt_a_q <= i_target_a_set | (tgt_a_q & ~target_reset);
         tgt_b_q <= i_target_b_set | (tgt_b_q & ~target_reset);
         tgt_c_q <= i_target_c_set | (tgt_c_q & ~target_reset);
      end
   end

   // strict below: a reading equal to the setting is healthy
   always_comb begin
      if (ctrl_q[relay_alarm_pkg::CTRL_DELTA_BIT]) begin
         uv_now = (i_volt_ab < uv_thr_q) | (i_volt_bc < uv_thr_q) | (i_volt_ca < uv_thr_q);
      end else begin
         uv_now = (i_volt_a < uv_thr_q) | (i_volt_b < uv_thr_q) | (i_volt_c < uv_thr_q);
      end
   end

   // one vector feeds status, readback and the seal-ins
   always_comb begin
      alarms = '0;
      alarms[relay_alarm_pkg::AL_PHASE_HS] = i_phase_hs_energized;
      alarms[relay_alarm_pkg::AL_GROUND_HS] = i_ground_hs_energized;
      alarms[relay_alarm_pkg::AL_TGT_A] = tgt_a_q;
      alarms[relay_alarm_pkg::AL_TGT_B] = tgt_b_q;
      alarms[relay_alarm_pkg::AL_TGT_C] = tgt_c_q;
      alarms[relay_alarm_pkg::AL_UV] = uv_now;
      alarms[relay_alarm_pkg::AL_RECL_DIS] = i_recloser_block_input |
         ctrl_q[relay_alarm_pkg::CTRL_LOCKOUT_FIRST_BIT];
      alarms[relay_alarm_pkg::AL_RC1] = over_thr(rc1_cnt_q, rc1_thr_q);
      alarms[relay_alarm_pkg::AL_RC2] = over_thr(rc2_cnt_q, rc2_thr_q);
      alarms[relay_alarm_pkg::AL_OC] = over_thr(oc_cnt_q, oc_thr_q);
      alarms[relay_alarm_pkg::AL_PHASE_HS_SEAL] = phase_seal_q;
      alarms[relay_alarm_pkg::AL_GROUND_HS_SEAL] = ground_seal_q;
      alarms[relay_alarm_pkg::AL_UV_SEAL] = uv_seal_q;
      alarms[relay_alarm_pkg::AL_RC_SEAL] = rc1_seal_q | rc2_seal_q;
   end

   // bit 13 clears both reclose seals, which share one alarm bit
   assign seal_clr = wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_SEAL_CLR) ? NA'(i_wb_dat) : '0;

   // seal-ins: base alarm wins over a clear in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_seal_q <= 1'b0;
         ground_seal_q <= 1'b0;
         uv_seal_q <= 1'b0;
         rc1_seal_q <= 1'b0;
         rc2_seal_q <= 1'b0;
      end else begin
         phase_seal_q <= alarms[relay_alarm_pkg::AL_PHASE_HS] |
            (phase_seal_q & ~seal_clr[relay_alarm_pkg::AL_PHASE_HS_SEAL]);
         ground_seal_q <= alarms[relay_alarm_pkg::AL_GROUND_HS] |
            (ground_seal_q & ~seal_clr[relay_alarm_pkg::AL_GROUND_HS_SEAL]);
         uv_seal_q <= alarms[relay_alarm_pkg::AL_UV] |
            (uv_seal_q & ~seal_clr[relay_alarm_pkg::AL_UV_SEAL]);
         rc1_seal_q <= alarms[relay_alarm_pkg::AL_RC1] |
            (rc1_seal_q & ~seal_clr[relay_alarm_pkg::AL_RC_SEAL]);
         rc2_seal_q <= alarms[relay_alarm_pkg::AL_RC2] |
            (rc2_seal_q & ~seal_clr[relay_alarm_pkg::AL_RC_SEAL]);
      end
   end

   // prev resets low, so a level already high out of reset counts as one event
   assign alarm_rise = alarms & ~alarms_prev_q;

   // interrupt: rising alarm edges are sticky; write one clears, new event wins
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alarms_prev_q <= '0;
         irq_stat_q <= '0;
      end else begin
         alarms_prev_q <= alarms;
         if (wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~NA'(i_wb_dat)) | alarm_rise;
         end else begin
            irq_stat_q <= irq_stat_q | alarm_rise;
         end
      end
   end

   // mask gates only the line; status keeps recording behind it
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_mask_q <= relay_alarm_pkg::MASK_RESET;
      end else if (wr_at(wr, i_wb_adr, relay_alarm_pkg::ADDR_IRQ_MASK)) begin
         irq_mask_q <= NA'(byte_merge(32'(irq_mask_q), i_wb_dat, i_wb_sel));
      end
   end

   // level output: stays high until the status bit is cleared or masked
   assign o_irq = |(irq_stat_q & irq_mask_q);

   // read data registered with the ack; unmapped reads return zero
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= '0;
      end else if (rd) begin
         case (i_wb_adr)
            relay_alarm_pkg::ADDR_CTRL: rdata_q <= 32'(ctrl_q);
            relay_alarm_pkg::ADDR_UV_THR: rdata_q <= 32'(uv_thr_q);
            relay_alarm_pkg::ADDR_RC1_THR: rdata_q <= 32'(rc1_thr_q);
            relay_alarm_pkg::ADDR_RC2_THR: rdata_q <= 32'(rc2_thr_q);
            relay_alarm_pkg::ADDR_OC_THR: rdata_q <= 32'(oc_thr_q);
            relay_alarm_pkg::ADDR_RC1_CNT: rdata_q <= 32'(rc1_cnt_q);
            relay_alarm_pkg::ADDR_RC2_CNT: rdata_q <= 32'(rc2_cnt_q);
            relay_alarm_pkg::ADDR_OC_CNT: rdata_q <= 32'(oc_cnt_q);
            relay_alarm_pkg::ADDR_ALARMS: rdata_q <= 32'(alarms);
            relay_alarm_pkg::ADDR_IRQ_STAT: rdata_q <= 32'(irq_stat_q);
            relay_alarm_pkg::ADDR_IRQ_MASK: rdata_q <= 32'(irq_mask_q);
            default: rdata_q <= '0;
         endcase
      end
   end

   assign o_wb_dat = rdata_q;

   // high-set alarms pass straight through; only their seals are stored
   assign o_phase_highset_trip_alarm = alarms[relay_alarm_pkg::AL_PHASE_HS];
   assign o_phase_highset_trip_sealed = phase_seal_q;
   assign o_ground_highset_trip_alarm = alarms[relay_alarm_pkg::AL_GROUND_HS];
   assign o_ground_highset_trip_sealed = ground_seal_q;
   assign o_phase_a_target_alarm = tgt_a_q;
   assign o_phase_b_target_alarm = tgt_b_q;
   assign o_phase_c_target_alarm = tgt_c_q;
   assign o_single_phase_undervolt_alarm = alarms[relay_alarm_pkg::AL_UV];
   assign o_single_phase_undervolt_sealed = uv_seal_q;
   assign o_recloser_disabled_alarm = alarms[relay_alarm_pkg::AL_RECL_DIS];
   // front-panel indicator shares the alarm's condition
   assign o_recloser_out_target = alarms[relay_alarm_pkg::AL_RECL_DIS];
   assign o_reclose_count_alarm_first = alarms[relay_alarm_pkg::AL_RC1];
   assign o_reclose_count_sealed_first = rc1_seal_q;
   assign o_reclose_count_alarm_second = alarms[relay_alarm_pkg::AL_RC2];
   assign o_reclose_count_sealed_second = rc2_seal_q;
   assign o_overcurrent_trip_count_alarm = alarms[relay_alarm_pkg::AL_OC];
endmodule
`default_nettype wire

// [verif/relay_alarm_output_logic_monitor.sv]
// concurrent checks on the relay alarm output block ports
`timescale 1ns/100ps
`default_nettype none
module relay_alarm_output_logic_monitor (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic o_wb_ack,
   input wire logic i_phase_hs_energized,
   input wire logic i_ground_hs_energized,
   input wire logic i_target_a_set,
   input wire logic i_target_b_set,
   input wire logic i_target_c_set,
   input wire logic i_target_reset_button,
   input wire logic i_recloser_block_input,
   input wire logic o_phase_highset_trip_alarm,
   input wire logic o_phase_highset_trip_sealed,
   input wire logic o_ground_highset_trip_alarm,
   input wire logic o_ground_highset_trip_sealed,
   input wire logic o_phase_a_target_alarm,
   input wire logic o_phase_b_target_alarm,
   input wire logic o_phase_c_target_alarm,
   input wire logic o_recloser_disabled_alarm,
   input wire logic o_recloser_out_target
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire logic req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   // any seal-clear write may drop a seal, whatever its data
   wire logic seal_wr = req && i_wb_we && (i_wb_adr == relay_alarm_pkg::ADDR_SEAL_CLR);
   sequence s_base_hit;
      o_phase_highset_trip_alarm;
   endsequence
   sequence s_ack_pulse;
      o_wb_ack ##1 !o_wb_ack;
   endsequence
   chk_phase_hs_follow: assert property (o_phase_highset_trip_alarm == i_phase_hs_energized)
      else $error("phase high-set alarm differs from element");
   chk_ground_hs_follow: assert property (o_ground_highset_trip_alarm == i_ground_hs_energized)
      else $error("ground high-set alarm differs from element");
   chk_tgt_a_set: assert property (i_target_a_set |=> o_phase_a_target_alarm)
      else $error("phase a target alarm not set");
   chk_tgt_b_reset: assert property (i_target_reset_button && !i_target_b_set |=> !o_phase_b_target_alarm)
      else $error("phase b target alarm not cleared");
   chk_tgt_c_cause: assert property ($rose(o_phase_c_target_alarm) |-> $past(i_target_c_set))
      else $error("phase c target alarm rose without target");
   chk_recl_dis_set: assert property (i_recloser_block_input |-> o_recloser_disabled_alarm)
      else $error("recloser disabled alarm missing while blocked");
   chk_recl_pair: assert property (o_recloser_disabled_alarm == o_recloser_out_target)
      else $error("recloser disabled alarm and out target differ");
   chk_seal_latch: assert property (s_base_hit |=> o_phase_highset_trip_sealed)
      else $error("phase seal did not latch");
   chk_seal_hold: assert property (o_ground_highset_trip_sealed && !seal_wr |=> o_ground_highset_trip_sealed)
      else $error("ground seal dropped without clear");
   chk_ack_once: assert property (req |=> s_ack_pulse)
      else $error("bus answer not a single cycle pulse");
endmodule
bind relay_alarm_output_logic relay_alarm_output_logic_monitor i_mon (.i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb,
   .i_wb_we, .i_wb_adr, .o_wb_ack, .i_phase_hs_energized, .i_ground_hs_energized, .i_target_a_set,
   .i_target_b_set, .i_target_c_set, .i_target_reset_button, .i_recloser_block_input,
   .o_phase_highset_trip_alarm, .o_phase_highset_trip_sealed, .o_ground_highset_trip_alarm,
   .o_ground_highset_trip_sealed, .o_phase_a_target_alarm, .o_phase_b_target_alarm, .o_phase_c_target_alarm,
   .o_recloser_disabled_alarm, .o_recloser_out_target);
`default_nettype wire

// [verif/relay_field_model.sv]
// behavioural protection elements, recloser logic and front panel
`timescale 1ns/100ps
`default_nettype none
module relay_field_model (
   input wire logic i_clk,
   output logic o_phase_hs,
   output logic o_ground_hs,
   output logic [2:0] o_tgt_set,
   output logic o_tgt_btn,
   output logic o_block,
   output logic o_reclose_op,
   output logic o_oc_trip_op
);
   initial begin
      {o_phase_hs, o_ground_hs, o_tgt_set, o_tgt_btn, o_block, o_reclose_op, o_oc_trip_op} = 9'h000;
   end
   task automatic set_lv(input logic ph, input logic gn, input logic blk);
      @(posedge i_clk);
      o_phase_hs <= ph;
      o_ground_hs <= gn;
      o_block <= blk;
   endtask
   task automatic pulse_tgt(input logic [2:0] t);
      @(posedge i_clk);
      o_tgt_set <= t;
      @(posedge i_clk);
      o_tgt_set <= 3'h0;
   endtask
   task automatic press_reset;
      @(posedge i_clk);
      o_tgt_btn <= 1'h1;
      @(posedge i_clk);
      o_tgt_btn <= 1'h0;
   endtask
   // each high cycle is one operation, so n back-to-back cycles count n
   task automatic ops(input logic rc, input logic oc, input int n);
      @(posedge i_clk);
      o_reclose_op <= rc;
      o_oc_trip_op <= oc;
      repeat (n) @(posedge i_clk);
      o_reclose_op <= 1'h0;
      o_oc_trip_op <= 1'h0;
   endtask
endmodule
`default_nettype wire

// [verif/test_relay_alarm_output_logic.sv]
// self-checking bench for the relay alarm output block
`timescale 1ns/100ps
`default_nettype none
module test_relay_alarm_output_logic;
   logic i_clk = 1'h0;
   logic i_rst_n = 1'h0;
   logic i_wb_cyc = 1'h0;
   logic i_wb_stb = 1'h0;
   logic i_wb_we = 1'h0;
   logic [7:0] i_wb_adr = 8'h00;
   logic [3:0] i_wb_sel = 4'h0;
   logic [31:0] i_wb_dat = 32'h0;
   logic [31:0] o_wb_dat, rd;
   logic [15:0] i_volt_a = 16'h00c8, i_volt_b = 16'h00c8, i_volt_c = 16'h00c8;
   logic [15:0] i_volt_ab = 16'h00c8, i_volt_bc = 16'h00c8, i_volt_ca = 16'h00c8;
   wire logic i_phase_hs_energized, i_ground_hs_energized, i_target_a_set, i_target_b_set, i_target_c_set;
   wire logic i_target_reset_button, i_recloser_block_input, i_reclose_op, i_oc_trip_op;
   logic o_wb_ack, o_phase_highset_trip_alarm, o_phase_highset_trip_sealed, o_ground_highset_trip_alarm;
   logic o_ground_highset_trip_sealed, o_phase_a_target_alarm, o_phase_b_target_alarm, o_phase_c_target_alarm;
   logic o_single_phase_undervolt_alarm, o_single_phase_undervolt_sealed, o_recloser_disabled_alarm;
   logic o_recloser_out_target, o_reclose_count_alarm_first, o_reclose_count_sealed_first;
   logic o_reclose_count_alarm_second, o_reclose_count_sealed_second, o_overcurrent_trip_count_alarm, o_irq;
   int bad_count = 0;
   int cmp_count = 0;
   logic [7:0] radr [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28,
      8'h2c, 8'h30};
   always #25 i_clk = ~i_clk;
   relay_alarm_output_logic i_relay_alarm_output_logic (.*);
   relay_field_model i_relay_field_model (.i_clk(i_clk), .o_phase_hs(i_phase_hs_energized),
      .o_ground_hs(i_ground_hs_energized), .o_tgt_set({i_target_c_set, i_target_b_set, i_target_a_set}),
      .o_tgt_btn(i_target_reset_button), .o_block(i_recloser_block_input), .o_reclose_op(i_reclose_op),
      .o_oc_trip_op(i_oc_trip_op));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      i_wb_cyc <= 1'h1;
      i_wb_stb <= 1'h1;
      i_wb_we <= we;
      i_wb_adr <= a;
      i_wb_dat <= d;
      i_wb_sel <= 4'hf;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wb_ack !== 1'h1 && n < 20);
      if (o_wb_ack !== 1'h1) begin
         check(o_wb_ack, 1'h1);
         report_and_stop;
      end else begin
         rd = o_wb_dat;
         i_wb_cyc <= 1'h0;
         i_wb_stb <= 1'h0;
         i_wb_we <= 1'h0;
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'h0, a, 32'h0);
      check(rd, exp);
   endtask
   // sample well after the edge so registered outputs have landed
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #10;
   endtask
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'h1;
      for (int k = 0; k < 13; k++) rd_chk(radr[k], (k >= 2 && k <= 4) ? 32'(relay_alarm_pkg::THR_RESET) : 32'h0);
      i_relay_field_model.set_lv(1'h1, 1'h0, 1'h0);
      step(2);
      check(o_phase_highset_trip_alarm, 1'h1);
      check(o_phase_highset_trip_sealed, 1'h1);
      i_relay_field_model.set_lv(1'h0, 1'h1, 1'h0);
      step(2);
      check(o_phase_highset_trip_alarm, 1'h0);
      check(o_phase_highset_trip_sealed, 1'h1);
      check({o_ground_highset_trip_alarm, o_ground_highset_trip_sealed}, 2'h3);
      i_relay_field_model.set_lv(1'h0, 1'h0, 1'h0);
      wb(1'h1, 8'h2c, 32'h0c00);
      step(1);
      check({o_phase_highset_trip_sealed, o_ground_highset_trip_sealed}, 2'h0);
      i_relay_field_model.pulse_tgt(3'h1);
      step(2);
      check({o_phase_b_target_alarm, o_phase_a_target_alarm}, 2'h1);
      i_relay_field_model.press_reset;
      step(2);
      check(o_phase_a_target_alarm, 1'h0);
      i_relay_field_model.pulse_tgt(3'h6);
      step(2);
      check({o_phase_c_target_alarm, o_phase_b_target_alarm}, 2'h3);
      wb(1'h1, 8'h00, 32'h4);
      step(2);
      check({o_phase_c_target_alarm, o_phase_b_target_alarm}, 2'h0);
      rd_chk(8'h00, 32'h0);
      wb(1'h1, 8'h04, 32'h0064);
      @(posedge i_clk) i_volt_b <= 16'h0063;
      step(2);
      check({o_single_phase_undervolt_alarm, o_single_phase_undervolt_sealed}, 2'h3);
      @(posedge i_clk) i_volt_b <= 16'h0064;
      step(1);
      check(o_single_phase_undervolt_alarm, 1'h0);
      wb(1'h1, 8'h00, 32'h1);
      @(posedge i_clk) i_volt_a <= 16'h0010;
      step(1);
      check(o_single_phase_undervolt_alarm, 1'h0);
      @(posedge i_clk) i_volt_bc <= 16'h0010;
      step(1);
      check(o_single_phase_undervolt_alarm, 1'h1);
      i_relay_field_model.set_lv(1'h0, 1'h0, 1'h1);
      step(1);
      check({o_recloser_disabled_alarm, o_recloser_out_target}, 2'h3);
      i_relay_field_model.set_lv(1'h0, 1'h0, 1'h0);
      step(1);
      check(o_recloser_disabled_alarm, 1'h0);
      wb(1'h1, 8'h00, 32'h2);
      step(1);
      check({o_recloser_disabled_alarm, o_recloser_out_target}, 2'h3);
      wb(1'h1, 8'h08, 32'h2);
      wb(1'h1, 8'h0c, 32'h4);
      i_relay_field_model.ops(1'h1, 1'h0, 3);
      step(2);
      check({o_reclose_count_alarm_first, o_reclose_count_alarm_second}, 2'h2);
      i_relay_field_model.ops(1'h1, 1'h0, 2);
      step(2);
      check(o_reclose_count_alarm_second, 1'h1);
      wb(1'h1, 8'h14, 32'h0);
      step(1);
      check({o_reclose_count_alarm_first, o_reclose_count_alarm_second}, 2'h1);
      check(o_reclose_count_sealed_first, 1'h1);
      rd_chk(8'h18, 32'h5);
      check(o_reclose_count_sealed_second, 1'h1);
      wb(1'h1, 8'h2c, 32'h2000);
      step(1);
      check({o_reclose_count_sealed_first, o_reclose_count_sealed_second}, 2'h1);
      wb(1'h1, 8'h10, 32'h1);
      i_relay_field_model.ops(1'h0, 1'h1, 1);
      step(2);
      check(o_overcurrent_trip_count_alarm, 1'h0);
      i_relay_field_model.ops(1'h0, 1'h1, 1);
      step(2);
      check(o_overcurrent_trip_count_alarm, 1'h1);
      wb(1'h1, 8'h1c, 32'hfffe);
      i_relay_field_model.ops(1'h0, 1'h1, 3);
      rd_chk(8'h1c, 32'hffff);
      wb(1'h1, 8'h1c, 32'h0);
      step(1);
      check(o_overcurrent_trip_count_alarm, 1'h0);
      wb(1'h1, 8'h24, 32'h3fff);
      wb(1'h1, 8'h28, 32'h1);
      i_relay_field_model.set_lv(1'h1, 1'h0, 1'h0);
      step(3);
      check(o_irq, 1'h1);
      rd_chk(8'h24, 32'h401);
      i_relay_field_model.set_lv(1'h0, 1'h0, 1'h0);
      wb(1'h1, 8'h28, 32'h0);
      step(1);
      check(o_irq, 1'h0);
      wb(1'h1, 8'h28, 32'h1);
      step(1);
      check(o_irq, 1'h1);
      wb(1'h1, 8'h24, 32'h1);
      step(1);
      check(o_irq, 1'h0);
      rd_chk(8'h24, 32'h400);
      rd_chk(8'h20, 32'h3560);
      report_and_stop;
   end
endmodule
`default_nettype wire
